// ### icps_pkg.sv
package icps_pkg;

  // ==========================================================================
  // register addresses (byte-wide register map)
  localparam logic [15:0] ADDR_FAULT_MASK = 16'h0537;
  localparam logic [15:0] ADDR_RANK_LOW = 16'h0538;
  localparam logic [15:0] ADDR_RANK_HIGH = 16'h0539;
  localparam logic [15:0] ADDR_SEAMLESS_MODE = 16'h053a;
  localparam logic [15:0] ADDR_PH_THR_LOW = 16'h053b;
  localparam logic [15:0] ADDR_PH_THR_HIGH = 16'h053c;
  localparam logic [15:0] ADDR_COARSE_LEN = 16'h053d;
  localparam logic [15:0] ADDR_COARSE_DLY = 16'h053e;
  localparam logic [15:0] ADDR_HIST_STATUS = 16'h053f;
  localparam logic [15:0] ADDR_FINE_LEN = 16'h0588;
  localparam logic [15:0] ADDR_DET_DLY_LOW = 16'h0589;
  localparam logic [15:0] ADDR_DET_DLY_HIGH = 16'h058a;

  // ==========================================================================
  // field positions
  localparam int ABSENT_MASK_LSB = 0;
  localparam int FREQ_MASK_LSB = 4;
  localparam int RANK_EVEN_LSB = 0;
  localparam int RANK_ODD_LSB = 4;
  localparam int HIST_GOOD_BIT = 1;
  localparam int FAST_ACQ_BIT = 2;

  // ==========================================================================
  // field widths (read masks)
  localparam logic [7:0] MASK_RANK = 8'h77;
  localparam logic [7:0] MASK_MODE = 8'h0f;
  localparam logic [7:0] MASK_THR_HIGH = 8'h03;
  localparam logic [7:0] MASK_COARSE = 8'h1f;
  localparam logic [7:0] MASK_FINE = 8'h0f;
  localparam logic [7:0] MASK_DLY_HIGH = 8'h1f;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_FAULT_MASK = 8'h00;
  localparam logic [7:0] RST_RANK = 8'h00;
  localparam logic [7:0] RST_SEAMLESS_MODE = 8'h0a;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] RST_SWITCH_MODE = 2'h0;

  // ==========================================================================
  // history accumulation length, in clock cycles of valid reference
  localparam logic [15:0] HIST_FILL_CYCLES = 16'h0400;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    SW_MANUAL = 2'b00,
    SW_AUTO_NONREV = 2'b01,
    SW_AUTO_REV = 2'b10,
    SW_RESERVED = 2'b11
  } icps_sw_mode_t;

  typedef enum logic [1:0] {
    LOOP_LOCKED = 2'b00,
    LOOP_HOLDOVER = 2'b01,
    LOOP_FREERUN = 2'b10
  } icps_loop_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } icps_reg_req_t;

  typedef struct packed {
    logic [3:0] signal_absent_flag;
    logic [3:0] freq_offset_fault;
  } icps_faults_t;

  typedef struct packed {
    logic [7:0] fault_mask;
    logic [7:0] rank_low;
    logic [7:0] rank_high;
    logic [7:0] seamless_mode;
    logic [7:0] thr_low;
    logic [7:0] thr_high;
    logic [7:0] coarse_len;
    logic [7:0] coarse_dly;
    logic [7:0] fine_len;
    logic [7:0] det_dly_low;
    logic [7:0] det_dly_high;
    logic [7:0] rdata;
    logic [1:0] sel;
    logic sel_valid;
    icps_loop_t loop;
    logic [15:0] hist_cnt;
    logic history_good;
    logic fast_acq;
  } icps_state_t;

endpackage

// ### icps_ref_src.sv
`timescale 1ns/1ps
// ==========================================================================
// four upstream references reporting their health
module icps_ref_src (
  input wire logic clk_sys_i, // clock
  input wire logic [3:0] lost_i, // commanded signal loss
  input wire logic [3:0] drift_i, // commanded frequency drift
  output icps_pkg::icps_faults_t faults_o // flags to the selector
);
  // detectors report one clock late
  always_ff @(posedge clk_sys_i) begin
    faults_o <= '{lost_i, drift_i};
  end
endmodule

// ### icps_selector.sv
// Operation
// - bits 3:0 mask per-input signal loss; 0 (default) uses it, 1 ignores.
// - bits 7:4 mask per-input freq fault; 0 (default) uses it, 1 ignores.
// - revert mode picks the available input of highest rank; non-revert does so only when the current input is unavailable.
// - 3-bit rank per input: 1 best, then 2, 3, 4; 0 excludes; 5-7 reserved.
// - rank 0 is never chosen automatically but stays selectable manually.
// - ranks packed two per byte: inputs 0 and 2 in bits 2:0, 1 and 3 in 6:4.
// - equal ranks resolve toward the lower input index.
// - selection drives holdover entry, so losing all inputs leaves lock.
// - status bit 1 reads 1 if history allows holdover, else 0 (free-run).
// - status bit 2 reads 1 while fast-acquisition bandwidth is in use.
// - mode: 0 manual (default), 1 non-revert, 2 revert, 3 reserved.
// - a valid input after a failure or switch clears and restarts history.
`timescale 1ns/1ps

module icps_selector (
  input wire logic clk_sys_i, // 40 MHz system clock
  input wire logic rst_b_i, // async reset, active low
  input wire icps_pkg::icps_reg_req_t reg_req_i, // register access request
  output logic [7:0] reg_rdata_o, // read data, one cycle after rd
  input wire icps_pkg::icps_faults_t faults_i, // per-input fault flags
  input wire logic [1:0] switch_mode_i, // switching mode code
  input wire logic [1:0] manual_sel_i, // input chosen in manual mode
  input wire logic force_hold_i, // force holdover or free-run
  output logic [1:0] sel_input_o, // selected reference index
  output logic sel_valid_o, // selected reference is usable
  output icps_pkg::icps_loop_t loop_state_o, // locked, holdover, free-run
  output logic fast_acq_o // fast-acquisition bandwidth in use
);

  icps_pkg::icps_state_t st;
  icps_pkg::icps_state_t next_st;

  logic [2:0] rank [4];
  logic [3:0] avail;
  logic [1:0] best_idx;
  logic best_found;
  logic [1:0] cand_idx;
  logic cand_ok;
  logic rank_ok;

  // ==========================================================================
  // rank ordering: 1 is best, 4 worst; returns true when a beats b
  function automatic logic rank_better(input logic [2:0] a,
                                       input logic [2:0] b);
    rank_better = (a < b);
  endfunction

  // usable rank: 1 to 4; zero excludes, 5-7 are reserved
  function automatic logic rank_usable(input logic [2:0] r);
    rank_usable = (r != 3'h0) && (r <= 3'h4);
  endfunction

  // ==========================================================================
  // rank unpacking and availability
  always_comb begin
    rank[0] = st.rank_low[icps_pkg::RANK_EVEN_LSB +: 3];
    rank[1] = st.rank_low[icps_pkg::RANK_ODD_LSB +: 3];
    rank[2] = st.rank_high[icps_pkg::RANK_EVEN_LSB +: 3];
    rank[3] = st.rank_high[icps_pkg::RANK_ODD_LSB +: 3];
    for (int i = 0; i < 4; i++) begin
      avail[i] = rank_usable(rank[i])
        && !(faults_i.signal_absent_flag[i]
             && !st.fault_mask[icps_pkg::ABSENT_MASK_LSB + i])
        && !(faults_i.freq_offset_fault[i]
             && !st.fault_mask[icps_pkg::FREQ_MASK_LSB + i]);
    end
  end

  // ==========================================================================
  // priority search, lower index wins ties by strict comparison
  always_comb begin
    best_idx = 2'h0;
    best_found = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (avail[i] && (!best_found
          || rank_better(rank[i], rank[best_idx]))) begin
        best_idx = 2'(i);
        best_found = 1'b1;
      end
    end
  end

  // ==========================================================================
  // input health of a given index (faults only, masks applied)
  function automatic logic healthy(input logic [1:0] idx,
                                   input icps_pkg::icps_faults_t f,
                                   input logic [7:0] m);
    healthy = !(f.signal_absent_flag[idx]
                && !m[icps_pkg::ABSENT_MASK_LSB + 32'(idx)])
      && !(f.freq_offset_fault[idx]
           && !m[icps_pkg::FREQ_MASK_LSB + 32'(idx)]);
  endfunction

  // ==========================================================================
  // candidate choice per switching mode
  always_comb begin
    cand_idx = st.sel;
    cand_ok = 1'b0;
    rank_ok = 1'b0;
    case (icps_pkg::icps_sw_mode_t'(switch_mode_i))
      icps_pkg::SW_MANUAL: begin
        cand_idx = manual_sel_i;
        cand_ok = healthy(manual_sel_i, faults_i, st.fault_mask);
      end
      icps_pkg::SW_AUTO_NONREV: begin
        // keep the current input while it stays available
        rank_ok = st.sel_valid && avail[st.sel];
        cand_idx = rank_ok ? st.sel : best_idx;
        cand_ok = rank_ok || best_found;
      end
      icps_pkg::SW_AUTO_REV: begin
        cand_idx = best_idx;
        cand_ok = best_found;
      end
      default: begin
        // reserved code holds the present choice
        cand_idx = st.sel;
        cand_ok = st.sel_valid && healthy(st.sel, faults_i, st.fault_mask);
      end
    endcase
  end

  // ==========================================================================
  // next state: registers, selection, loop state, history
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    // register writes
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        icps_pkg::ADDR_FAULT_MASK: next_st.fault_mask = reg_req_i.wdata;
        icps_pkg::ADDR_RANK_LOW:
          next_st.rank_low = reg_req_i.wdata & icps_pkg::MASK_RANK;
        icps_pkg::ADDR_RANK_HIGH:
          next_st.rank_high = reg_req_i.wdata & icps_pkg::MASK_RANK;
        icps_pkg::ADDR_SEAMLESS_MODE:
          next_st.seamless_mode = reg_req_i.wdata & icps_pkg::MASK_MODE;
        icps_pkg::ADDR_PH_THR_LOW: next_st.thr_low = reg_req_i.wdata;
        icps_pkg::ADDR_PH_THR_HIGH:
          next_st.thr_high = reg_req_i.wdata & icps_pkg::MASK_THR_HIGH;
        icps_pkg::ADDR_COARSE_LEN:
          next_st.coarse_len = reg_req_i.wdata & icps_pkg::MASK_COARSE;
        icps_pkg::ADDR_COARSE_DLY:
          next_st.coarse_dly = reg_req_i.wdata & icps_pkg::MASK_COARSE;
        icps_pkg::ADDR_FINE_LEN:
          next_st.fine_len = reg_req_i.wdata & icps_pkg::MASK_FINE;
        icps_pkg::ADDR_DET_DLY_LOW: next_st.det_dly_low = reg_req_i.wdata;
        icps_pkg::ADDR_DET_DLY_HIGH:
          next_st.det_dly_high = reg_req_i.wdata & icps_pkg::MASK_DLY_HIGH;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // register reads, data valid the cycle after the strobe
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        icps_pkg::ADDR_FAULT_MASK: next_st.rdata = st.fault_mask;
        icps_pkg::ADDR_RANK_LOW: next_st.rdata = st.rank_low;
        icps_pkg::ADDR_RANK_HIGH: next_st.rdata = st.rank_high;
        icps_pkg::ADDR_SEAMLESS_MODE: next_st.rdata = st.seamless_mode;
        icps_pkg::ADDR_PH_THR_LOW: next_st.rdata = st.thr_low;
        icps_pkg::ADDR_PH_THR_HIGH: next_st.rdata = st.thr_high;
        icps_pkg::ADDR_COARSE_LEN: next_st.rdata = st.coarse_len;
        icps_pkg::ADDR_COARSE_DLY: next_st.rdata = st.coarse_dly;
        icps_pkg::ADDR_HIST_STATUS: begin
          next_st.rdata[icps_pkg::HIST_GOOD_BIT] = st.history_good;
          next_st.rdata[icps_pkg::FAST_ACQ_BIT] = st.fast_acq;
        end
        icps_pkg::ADDR_FINE_LEN: next_st.rdata = st.fine_len;
        icps_pkg::ADDR_DET_DLY_LOW: next_st.rdata = st.det_dly_low;
        icps_pkg::ADDR_DET_DLY_HIGH: next_st.rdata = st.det_dly_high;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // selection result steers the loop state
    next_st.sel = cand_idx;
    next_st.sel_valid = cand_ok && !force_hold_i;
    if (cand_ok && !force_hold_i) begin
      next_st.loop = icps_pkg::LOOP_LOCKED;
    end else if (st.history_good) begin
      next_st.loop = icps_pkg::LOOP_HOLDOVER;
    end else begin
      next_st.loop = icps_pkg::LOOP_FREERUN;
    end
    // history: cleared on a fresh lock or switch, then accumulates
    if (next_st.sel_valid && (!st.sel_valid || cand_idx != st.sel)) begin
      next_st.hist_cnt = 16'h0000;
      next_st.history_good = 1'b0;
    end else if (next_st.sel_valid) begin
      if (st.hist_cnt == icps_pkg::HIST_FILL_CYCLES) begin
        next_st.history_good = 1'b1;
      end else begin
        next_st.hist_cnt = st.hist_cnt + 16'h0001;
      end
    end
    // fast acquisition while history is still being rebuilt after lock
    next_st.fast_acq = next_st.sel_valid && !next_st.history_good;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.seamless_mode <= icps_pkg::RST_SEAMLESS_MODE;
      st.fault_mask <= icps_pkg::RST_FAULT_MASK;
      st.rank_low <= icps_pkg::RST_RANK;
      st.rank_high <= icps_pkg::RST_RANK;
      st.loop <= icps_pkg::LOOP_FREERUN;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata_o = st.rdata;
  assign sel_input_o = st.sel;
  assign sel_valid_o = st.sel_valid;
  assign loop_state_o = st.loop;
  assign fast_acq_o = st.fast_acq;

endmodule

// ### icps_selector_chk.sv
`timescale 1ns/1ps
// ==========================================================================
// port checker for the reference selector
module icps_selector_chk (
  input wire logic clk_sys_i, // clock
  input wire logic rst_b_i, // reset, active low
  input wire icps_pkg::icps_reg_req_t reg_req_i, // register request
  input wire logic [7:0] reg_rdata_o, // read data
  input wire icps_pkg::icps_faults_t faults_i, // fault flags
  input wire logic [1:0] switch_mode_i, // switching mode
  input wire logic [1:0] manual_sel_i, // manual choice
  input wire logic force_hold_i, // forced holdover
  input wire logic [1:0] sel_input_o, // chosen index
  input wire logic sel_valid_o, // choice usable
  input wire icps_pkg::icps_loop_t loop_state_o, // loop state
  input wire logic fast_acq_o // fast bandwidth
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  property p_status_rd;
    reg_req_i.rd && reg_req_i.addr == 16'h053f |=> (reg_rdata_o & 8'hf9) ==
      8'h00 && reg_rdata_o[2] == $past(fast_acq_o) && !(&reg_rdata_o[2:1]);
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("bad status read");
  property p_fast_valid;
    fast_acq_o |-> sel_valid_o;
  endproperty
  a_fast_valid: assert property (p_fast_valid)
    else $error("fast unlocked");
  property p_locked;
    sel_valid_o == (loop_state_o == icps_pkg::LOOP_LOCKED);
  endproperty
  a_locked: assert property (p_locked)
    else $error("valid not locked");
  property p_force;
    force_hold_i |=> !sel_valid_o && loop_state_o != icps_pkg::LOOP_LOCKED;
  endproperty
  a_force: assert property (p_force)
    else $error("force ignored");
  property p_hold_hist;
    loop_state_o == icps_pkg::LOOP_HOLDOVER |->
      $past(loop_state_o) != icps_pkg::LOOP_FREERUN;
  endproperty
  a_hold_hist: assert property (p_hold_hist)
    else $error("no history");
  property p_manual;
    switch_mode_i == 2'h0 && !force_hold_i |=>
      sel_input_o == $past(manual_sel_i);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual choice");
  property p_manual_ok;
    switch_mode_i == 2'h0 && !force_hold_i && faults_i == '0 |=> sel_valid_o;
  endproperty
  a_manual_ok: assert property (p_manual_ok)
    else $error("manual lost");
  property p_relock;
    $rose(sel_valid_o) |-> fast_acq_o;
  endproperty
  a_relock: assert property (p_relock)
    else $error("history kept");
endmodule

// ### input_clock_priority_selector_test.sv
`timescale 1ns/1ps
// ==========================================================================
// self-checking bench for the reference selector
module input_clock_priority_selector_test;
  localparam logic [15:0] AD[13] = '{16'h0537, 16'h0538, 16'h0539, 16'h053a,
    16'h053b, 16'h053c, 16'h053d, 16'h053e, 16'h053f, 16'h0588, 16'h0589,
    16'h058a, 16'h0540};
  localparam logic [7:0] WM[13] = '{8'hff, 8'h77, 8'h77, 8'h0f, 8'hff,
    8'h03, 8'h1f, 8'h1f, 8'h00, 8'h0f, 8'hff, 8'h1f, 8'h00};
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  icps_pkg::icps_reg_req_t req = '0;
  logic [3:0] lost = 4'h0;
  logic [3:0] drift = 4'h0;
  logic [1:0] mode = 2'h0;
  logic [1:0] msel = 2'h0;
  logic hold = 1'b1;
  logic probe = 1'b0;
  logic rd_q = 1'b0;
  icps_pkg::icps_faults_t flt;
  icps_pkg::icps_loop_t loop;
  logic [7:0] rdata, mk, wv;
  logic [1:0] sel, bi, ms, md;
  logic valid, fast;
  logic [3:0] lv, dv, ok;
  logic [2:0] rk[4];
  logic [2:0] best;
  logic [15:0] e;
  logic [7:0] obs;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int compares = 0;
  icps_ref_src src_u (.clk_sys_i(clk_sys_i), .lost_i(lost), .drift_i(drift),
    .faults_o(flt));
  icps_selector dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .faults_i(flt),
    .switch_mode_i(mode), .manual_sel_i(msel), .force_hold_i(hold),
    .sel_input_o(sel), .sel_valid_o(valid), .loop_state_o(loop),
    .fast_acq_o(fast));
  // clock and hang guard
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (4000) @(posedge clk_sys_i);
    num_errors++;
    wrap_up();
  end
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [7:0] st(input logic [1:0] l, input logic v,
      input logic [1:0] s, input logic f);
    return {2'h0, l, v, s, f};
  endfunction
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys_i);
    req <= '0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] want);
    exp_q.push_back({8'hff, want});
    acc(1'b0, a, 8'h00);
  endtask
  task automatic look(input logic [7:0] m, input logic [7:0] want);
    repeat (4) @(posedge clk_sys_i);
    exp_q.push_back({m, want & m});
    probe <= 1'b1;
    @(posedge clk_sys_i);
    probe <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // compare each result with the oldest note when it appears
  always @(posedge clk_sys_i) begin
    if (rd_q || probe) begin
      e = exp_q.pop_front();
      obs = rd_q ? rdata : st(loop, valid, sel, fast);
      check(obs & e[15:8], e[7:0]);
    end
    rd_q <= req.rd;
  end
  // main sequence
  initial begin
    wv = 8'($urandom(21631));
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 0; i < 13; i++) rd(AD[i], i == 3 ? 8'h0a : 8'h00);
    for (int i = 0; i < 13; i++) begin
      wv = (i == 3) ? 8'h0a : 8'hff;
      acc(1'b1, AD[i], wv);
      rd(AD[i], wv & WM[i]);
    end
    hold <= 1'b0;
    for (int n = 0; n < 40; n++) begin
      mk = 8'($urandom);
      lv = 4'($urandom);
      dv = 4'($urandom);
      ms = 2'($urandom);
      md = ($urandom % 2) ? 2'h2 : 2'h0;
      for (int i = 0; i < 4; i++) rk[i] = 3'($urandom % 6);
      acc(1'b1, 16'h0537, mk);
      acc(1'b1, 16'h0538, {1'b0, rk[1], 1'b0, rk[0]});
      acc(1'b1, 16'h0539, {1'b0, rk[3], 1'b0, rk[2]});
      mode <= md;
      msel <= ms;
      lost <= lv;
      drift <= dv;
      best = 3'h0;
      bi = 2'h0;
      for (int i = 0; i < 4; i++) begin
        ok[i] = !(lv[i] && !mk[i]) && !(dv[i] && !mk[i + 4]);
        if (ok[i] && rk[i] inside {[1:4]} && (best == 0 || rk[i] < best)) begin
          best = rk[i];
          bi = 2'(i);
        end
      end
      if (md == 2'h0) begin
        best = {2'h0, ok[ms]};
        bi = ms;
      end
      look(best != 0 ? 8'hff : 8'hf9, st(best != 0 ? 2'h0 : 2'h2, best != 0,
        bi, best != 0));
    end
    mode <= 2'h2;
    lost <= 4'h0;
    drift <= 4'h0;
    acc(1'b1, 16'h0537, 8'h00);
    acc(1'b1, 16'h0538, 8'h21);
    acc(1'b1, 16'h0539, 8'h00);
    repeat (1100) @(posedge clk_sys_i);
    rd(16'h053f, 8'h02);
    look(8'hff, st(2'h0, 1'b1, 2'h0, 1'b0));
    lost <= 4'hf;
    look(8'hf9, st(2'h1, 1'b0, 2'h0, 1'b0));
    lost <= 4'h0;
    look(8'hff, st(2'h0, 1'b1, 2'h0, 1'b1));
    rd(16'h053f, 8'h04);
    mode <= 2'h1;
    lost <= 4'h1;
    look(8'hff, st(2'h0, 1'b1, 2'h1, 1'b1));
    lost <= 4'h0;
    look(8'hff, st(2'h0, 1'b1, 2'h1, 1'b1));
    // reserved mode keeps the present input even when its rank is cleared
    mode <= 2'h3;
    acc(1'b1, 16'h0538, 8'h01);
    look(8'hff, st(2'h0, 1'b1, 2'h1, 1'b1));
    hold <= 1'b1;
    look(8'hf9, st(2'h2, 1'b0, 2'h0, 1'b0));
    wrap_up();
  end
endmodule
bind icps_selector icps_selector_chk chk_u (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .faults_i(faults_i), .switch_mode_i(switch_mode_i),
  .manual_sel_i(manual_sel_i), .force_hold_i(force_hold_i),
  .sel_input_o(sel_input_o), .sel_valid_o(sel_valid_o),
  .loop_state_o(loop_state_o), .fast_acq_o(fast_acq_o));
